/* File: core/spi_ctrl_defines.svh */
// register indices, field positions, reset values and divider counts
`ifndef SPI_CTRL_DEFINES_SVH
`define SPI_CTRL_DEFINES_SVH
`define IDX_CONTROL_A      3'h0
`define IDX_CONTROL_B      3'h1
`define IDX_INT_ENABLES    3'h2
`define IDX_FLAGS          3'h3
`define IDX_TRANSFER_BYTE  3'h4
`define REG_COUNT          3'h5
`define REG_RESET          8'h00
`define CA_ORDER           6
`define CA_MASTER          5
`define CA_DOUBLE          4
`define CA_DIV_HI          2
`define CA_DIV_LO          1
`define CA_ENABLE          0
`define CB_BUFFERED_OPERATION_ENABLE           7
`define CB_BUFFER_WAIT_FOR_RECEIVE           6
`define CB_SSD             2
`define CB_MODE_HI         1
`define CB_MODE_LO         0
`define IE_RXC             7
`define IE_SINGLE          0
`define FB_RXC             7
`define FB_TXC             6
`define FB_SSI             4
`define HALF_DIVIDE_BY_FOUR          7'h02
`define HALF_DIV16         7'h08
`define HALF_DIV64         7'h20
`define HALF_DIVIDE_BY_128        7'h40
`define LAST_EDGE          4'hf
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

/* File: core/spi_ctrl_pkg.sv */
// types shared by the serial controller
`default_nettype none
package spi_ctrl_pkg;
  typedef enum logic {ST_IDLE, ST_RUN} xfer_state_t;
  typedef enum logic [1:0] {
    divide_by_four, divide_by_16, divide_by_64, divide_by_128
  } clk_div_t;
endpackage
`default_nettype wire

/* File: core/spi_ctrl.sv */
// byte-wide serial interface, master or slave, with axi4-lite registers
// Behaviour
// - order bit 0 shifts msb first, 1 shifts lsb first
// - role bit 1 makes master, 0 makes slave
// - master with select input low drops role bit, sets normal flag, or select flag in buffer mode
// - select-disable bit 1 keeps master role regardless of select line
// - clock-double bit doubles generated serial clock in master role
// - divider field 0..3 divides peripheral clock by 4, 16, 64, 128
// - divider field has no effect in slave role
// - buffer enable gives two receive buffers, one transmit, split flags
// - wait-for-receive 0: written data enters shifter after one transfer
// - wait-for-receive 1: first write while idle, select high loads shifter
// - mode field picks sample and setup edges per clock phase
// - serial clock idles low for rising leading edge, else high
// - buffer mode: four enables gate receive, transfer, empty, select flags
// - buffer-mode enables read zero outside buffer mode
// - outside buffer mode single enable gates normal flag request
// - normal mode sets flag after a full byte shifted
// - normal flag clears when interrupt vector is taken
// - flags read with flag set then data access clears normal flag
// - outside buffer mode, data write before byte shifted out sets collision flag
// - flags read with collision set then data access clears it
// - slave select high resets slave transfer, byte abandoned
// - buffer write drops empty flag; move into shifter raises it
`include "spi_ctrl_defines.svh"
`default_nettype none
module spi_ctrl #(
  parameter int ADDR_W = 5
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              ss_dir_input,
  input  wire logic              vector_ack,
  input  wire logic              sck_in,
  input  wire logic              mosi_in,
  input  wire logic              miso_in,
  input  wire logic              ss_n_in,
  output logic                   sck_out,
  output logic                   sck_oe,
  output logic                   mosi_out,
  output logic                   mosi_oe,
  output logic                   miso_out,
  output logic                   miso_oe,
  output logic                   irq_req
);
  if (ADDR_W < 5) begin : g_chk
    $error("ADDR_W must be at least 5");
  end

  function automatic logic [6:0] half_period(logic [1:0] div, logic dbl);
    logic [6:0] h;
    h = `HALF_DIVIDE_BY_FOUR;
    unique case (spi_ctrl_pkg::clk_div_t'(div))
      spi_ctrl_pkg::divide_by_four: h = `HALF_DIVIDE_BY_FOUR;
      spi_ctrl_pkg::divide_by_16:   h = `HALF_DIV16;
      spi_ctrl_pkg::divide_by_64:   h = `HALF_DIV64;
      spi_ctrl_pkg::divide_by_128:  h = `HALF_DIVIDE_BY_128;
    endcase
    return dbl ? (h >> 1) : h;
  endfunction
  function automatic logic [7:0] shift_in(logic [7:0] v, logic lsb, logic b);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction
  function automatic logic first_bit(logic [7:0] v, logic lsb);
    return lsb ? v[0] : v[7];
  endfunction
  function automatic logic addr_hit(logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && ((a >> 5) == '0) && (a[4:2] < `REG_COUNT);
  endfunction

  // pin synchronisers and register state
  logic [1:0] sck_s, mosi_s, miso_s, ss_s;
  logic       sck_d_ff;
  logic       order_ff, master_ff, dbl_ff, en_ff;
  logic [1:0] clock_divider_field_ff, mode_ff;
  logic       buffered_operation_enable_ff, buffer_wait_for_receive_ff, ssd_ff;
  logic [4:0] ien_ff;
  logic       if_ff, write_collision_flag_ff, txc_ff, ssi_ff, ovf_ff, arm_if_ff, arm_wc_ff;
  logic [7:0] sr_ff, txbuf_ff, rx0_ff, rx1_ff;
  logic       txfull_ff, pending_ff, rx0_vld_ff, rx1_vld_ff, out_ff;
  spi_ctrl_pkg::xfer_state_t state_ff;
  logic [6:0] tick_cnt_ff, gap_ff;
  logic [3:0] edge_cnt_ff;
  logic       aw_got_ff, w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic       wstrb0_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {sck_s, mosi_s, miso_s, ss_s} <= 8'hff;
      sck_d_ff <= 1'b1;
    end else begin
      sck_s    <= {sck_s[0], sck_in};
      mosi_s   <= {mosi_s[0], mosi_in};
      miso_s   <= {miso_s[0], miso_in};
      ss_s     <= {ss_s[0], ss_n_in};
      sck_d_ff <= sck_s[1];
    end
  end

  // bus decode
  wire       aw_hs   = awvalid & awready;
  wire       w_hs    = wvalid & wready;
  wire       ar_hs   = arvalid & arready;
  wire       do_wr   = aw_got_ff & w_got_ff & ~bvalid;
  wire       wr_ok   = do_wr & addr_hit(awaddr_ff) & wstrb0_ff;
  wire [2:0] wr_idx  = awaddr_ff[4:2];
  wire       wr_ca   = wr_ok & (wr_idx == `IDX_CONTROL_A);
  wire       wr_cb   = wr_ok & (wr_idx == `IDX_CONTROL_B);
  wire       wr_ie   = wr_ok & (wr_idx == `IDX_INT_ENABLES);
  wire       wr_fl   = wr_ok & (wr_idx == `IDX_FLAGS);
  wire       wr_dt   = wr_ok & (wr_idx == `IDX_TRANSFER_BYTE);
  wire       rd_ok   = ar_hs & addr_hit(araddr);
  wire [2:0] rd_idx  = araddr[4:2];
  wire       rd_fl   = rd_ok & (rd_idx == `IDX_FLAGS);
  wire       rd_dt   = rd_ok & (rd_idx == `IDX_TRANSFER_BYTE);
  wire       data_acc = rd_dt | wr_dt;

  // transfer engine
  wire       mst        = en_ff & master_ff;
  wire       slv        = en_ff & ~master_ff;
  wire       ss_lo      = ~ss_s[1];
  wire       mode_fault = mst & ss_dir_input & ss_lo & ~ssd_ff;
  wire       cpol       = mode_ff[`CB_MODE_HI];
  wire       cpha       = mode_ff[`CB_MODE_LO];
  wire       running    = (state_ff == spi_ctrl_pkg::ST_RUN);
  wire [6:0] half_m1    = half_period(clock_divider_field_ff, dbl_ff) - 7'h01;
  wire       tick       = running & (tick_cnt_ff == 7'h00);
  wire       s_rise     = sck_s[1] & ~sck_d_ff;
  wire       s_fall     = ~sck_s[1] & sck_d_ff;
  wire       s_edge     = slv & ss_lo & (s_rise | s_fall);
  wire       s_lead     = (s_rise & ~cpol) | (s_fall & cpol);
  wire       any_edge   = tick | s_edge;
  wire       lead       = mst ? ~edge_cnt_ff[0] : s_lead;
  wire       sample_ev  = any_edge & (lead ^ cpha);
  wire       setup_ev   = any_edge & ~(lead ^ cpha);
  wire       done_ev    = any_edge & (edge_cnt_ff == `LAST_EDGE);
  wire       in_bit     = mst ? miso_s[1] : mosi_s[1];
  wire [7:0] shifted    = shift_in(sr_ff, order_ff, in_bit);
  wire [7:0] rx_byte    = sample_ev ? shifted : sr_ff;
  wire       busy       = running | (edge_cnt_ff != 4'h0);
  wire       abort      = ~en_ff | (slv & ~ss_lo) | mode_fault;
  wire       direct_ok  = buffered_operation_enable_ff
                          ? (buffer_wait_for_receive_ff & en_ff & ~ss_lo & ~busy
                             & ~pending_ff & ~txfull_ff)
                          : ~busy;
  wire       wr_to_sr   = wr_dt & direct_ok;
  wire       wr_to_buf  = wr_dt & buffered_operation_enable_ff & ~direct_ok & ~txfull_ff;
  wire       move_tx    = done_ev & buffered_operation_enable_ff & txfull_ff;
  wire       start      = mst & ~running & ~mode_fault
                          & (pending_ff | (buffered_operation_enable_ff & txfull_ff));
  wire       dre        = ~txfull_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || abort || done_ev) begin
      state_ff <= spi_ctrl_pkg::ST_IDLE;
    end else if (start) begin
      state_ff <= spi_ctrl_pkg::ST_RUN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !running || tick) begin
      tick_cnt_ff <= half_m1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff - 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || abort) begin
      edge_cnt_ff <= 4'h0;
    end else if (any_edge) begin
      edge_cnt_ff <= edge_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_ff <= `REG_RESET;
    end else if (move_tx) begin
      sr_ff <= txbuf_ff;
    end else if (done_ev) begin
      sr_ff <= rx_byte;
    end else if (sample_ev) begin
      sr_ff <= shifted;
    end else if (wr_to_sr) begin
      sr_ff <= wbyte_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_ff <= 1'b0;
      txfull_ff  <= 1'b0;
      txbuf_ff   <= `REG_RESET;
    end else begin
      if (wr_to_sr || move_tx) begin
        pending_ff <= 1'b1;
      end else if (start || !en_ff || (s_edge && !busy)) begin
        pending_ff <= 1'b0;
      end
      if (wr_to_buf) begin
        txfull_ff <= 1'b1;
        txbuf_ff  <= wbyte_ff;
      end else if (move_tx || !buffered_operation_enable_ff) begin
        txfull_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_ff <= 1'b0;
    end else if (!busy || setup_ev) begin
      out_ff <= first_bit(sr_ff, order_ff);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      sck_out <= running ? (sck_out ^ tick) : cpol;
      sck_oe  <= mst;
      mosi_oe <= mst;
      miso_oe <= slv & ss_lo;
    end
  end
  assign mosi_out = out_ff;
  assign miso_out = out_ff;

  // receive buffers: pop on read, then push the finished byte
  wire pop   = rd_dt & buffered_operation_enable_ff;
  wire flush = wr_fl & buffered_operation_enable_ff & wbyte_ff[`FB_RXC];
  wire v1a   = pop ? rx0_vld_ff : rx1_vld_ff;
  wire v0a   = ~pop & rx0_vld_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {rx0_vld_ff, rx1_vld_ff} <= 2'h0;
      rx0_ff <= `REG_RESET;
      rx1_ff <= `REG_RESET;
    end else begin
      rx1_vld_ff <= ~flush & (v1a | (done_ev & buffered_operation_enable_ff));
      rx0_vld_ff <= ~flush & (v0a | (done_ev & buffered_operation_enable_ff & v1a));
      if (pop) begin
        rx1_ff <= rx0_ff;
      end
      if (done_ev && (!buffered_operation_enable_ff || !v1a)) begin
        rx1_ff <= rx_byte;
      end else if (done_ev && !v0a) begin
        rx0_ff <= rx_byte;
      end
    end
  end

  // flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {if_ff, write_collision_flag_ff, txc_ff, ssi_ff, ovf_ff} <= 5'h00;
      {arm_if_ff, arm_wc_ff} <= 2'h0;
    end else begin
      if ((done_ev && !buffered_operation_enable_ff) || (mode_fault && !buffered_operation_enable_ff)) begin
        if_ff <= 1'b1;
      end else if (vector_ack || (data_acc && arm_if_ff)) begin
        if_ff <= 1'b0;
      end
      if (wr_dt && !buffered_operation_enable_ff && busy) begin
        write_collision_flag_ff <= 1'b1;
      end else if (data_acc && arm_wc_ff) begin
        write_collision_flag_ff <= 1'b0;
      end
      if (rd_fl && !buffered_operation_enable_ff) begin
        arm_if_ff <= if_ff;
        arm_wc_ff <= write_collision_flag_ff;
      end else if (data_acc) begin
        {arm_if_ff, arm_wc_ff} <= 2'h0;
      end
      if (done_ev && buffered_operation_enable_ff && !txfull_ff) begin
        txc_ff <= 1'b1;
      end else if (wr_fl && wbyte_ff[`FB_TXC]) begin
        txc_ff <= 1'b0;
      end
      if (mode_fault && buffered_operation_enable_ff) begin
        ssi_ff <= 1'b1;
      end else if (wr_fl && wbyte_ff[`FB_SSI]) begin
        ssi_ff <= 1'b0;
      end
      if (done_ev && buffered_operation_enable_ff && v1a && v0a) begin
        ovf_ff <= 1'b1;
      end else if (pop || flush) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {order_ff, master_ff, dbl_ff, clock_divider_field_ff, en_ff} <= 6'h00;
      {buffered_operation_enable_ff, buffer_wait_for_receive_ff, ssd_ff, mode_ff} <= 5'h00;
      ien_ff <= 5'h00;
    end else begin
      if (wr_ca) begin
        order_ff  <= wbyte_ff[`CA_ORDER];
        master_ff <= wbyte_ff[`CA_MASTER];
        dbl_ff    <= wbyte_ff[`CA_DOUBLE];
        clock_divider_field_ff  <= wbyte_ff[`CA_DIV_HI:`CA_DIV_LO];
        en_ff     <= wbyte_ff[`CA_ENABLE];
      end else if (mode_fault) begin
        master_ff <= 1'b0;
      end
      if (wr_cb) begin
        buffered_operation_enable_ff <= wbyte_ff[`CB_BUFFERED_OPERATION_ENABLE];
        buffer_wait_for_receive_ff <= wbyte_ff[`CB_BUFFER_WAIT_FOR_RECEIVE];
        ssd_ff   <= wbyte_ff[`CB_SSD];
        mode_ff  <= wbyte_ff[`CB_MODE_HI:`CB_MODE_LO];
      end
      if (wr_ie) begin
        ien_ff <= {wbyte_ff[`IE_RXC:`FB_SSI], wbyte_ff[`IE_SINGLE]};
      end
    end
  end

  wire [3:0] buf_flags = {rx1_vld_ff, txc_ff, dre, ssi_ff};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= buffered_operation_enable_ff ? |(buf_flags & ien_ff[4:1])
                          : (ien_ff[0] & if_ff);
    end
  end

  // register read mux
  logic [7:0] rd_val;
  always_comb begin
    rd_val = `REG_RESET;
    unique case (rd_idx)
      `IDX_CONTROL_A: rd_val = {1'b0, order_ff, master_ff, dbl_ff,
                                1'b0, clock_divider_field_ff, en_ff};
      `IDX_CONTROL_B: rd_val = {buffered_operation_enable_ff, buffer_wait_for_receive_ff, 3'h0, ssd_ff, mode_ff};
      `IDX_INT_ENABLES: rd_val = {buffered_operation_enable_ff ? ien_ff[4:1] : 4'h0,
                                  3'h0, ien_ff[0]};
      `IDX_FLAGS: rd_val = buffered_operation_enable_ff ? {buf_flags, 3'h0, ovf_ff}
                                    : {if_ff, write_collision_flag_ff, 6'h00};
      `IDX_TRANSFER_BYTE: rd_val = rx1_ff;
      default: rd_val = `REG_RESET;
    endcase
  end

  // axi4-lite slave, one write and one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_got_ff, w_got_ff, bvalid} <= 3'h0;
      {awready, wready} <= 2'h3;
      awaddr_ff <= '0;
      wbyte_ff  <= `REG_RESET;
      wstrb0_ff <= 1'b0;
      bresp     <= `RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_got_ff <= 1'b1;
        awready   <= 1'b0;
        awaddr_ff <= awaddr;
      end
      if (w_hs) begin
        w_got_ff  <= 1'b1;
        wready    <= 1'b0;
        wbyte_ff  <= wdata[7:0];
        wstrb0_ff <= wstrb[0];
      end
      if (do_wr) begin
        {aw_got_ff, w_got_ff} <= 2'h0;
        bvalid <= 1'b1;
        bresp  <= addr_hit(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `RESP_OKAY;
    end else if (ar_hs) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h0, addr_hit(araddr) ? rd_val : `REG_RESET};
      rresp   <= addr_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // checks
  always_ff @(posedge aclk) begin
    if (!aresetn || tick || !running) begin
      gap_ff <= 7'h00;
    end else begin
      gap_ff <= gap_ff + 7'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_fault;
    mode_fault && !buffered_operation_enable_ff && !wr_ca;
  endsequence
  sequence s_dropped;
    !master_ff && if_ff;
  endsequence

  AST_FAULT_DROPS_ROLE: assert property (s_fault |=> s_dropped)
    else $error("select low did not drop master role");
  AST_SSD_KEEPS_ROLE: assert property (
    en_ff && master_ff && ssd_ff && !wr_ca |=> master_ff)
    else $error("master role lost with select disabled");
  AST_TICK_SPACING: assert property (
    tick && $stable({clock_divider_field_ff, dbl_ff}) && edge_cnt_ff != 4'h0
    |-> gap_ff == half_m1)
    else $error("serial clock half period wrong");
  AST_IDLE_LEVEL: assert property (
    !running && !wr_cb |=> sck_out == cpol)
    else $error("serial clock idle level wrong");
  AST_DISABLED_QUIET: assert property (
    !en_ff |=> !running && !sck_oe && edge_cnt_ff == 4'h0)
    else $error("engine active while disabled");
  AST_SLAVE_RESET: assert property (
    slv && !ss_lo |=> edge_cnt_ff == 4'h0)
    else $error("slave counter kept with select high");
  AST_BYTE_FLAG: assert property (
    done_ev && !buffered_operation_enable_ff |=> if_ff)
    else $error("flag not set after byte");
  AST_COLLISION: assert property (
    wr_dt && !buffered_operation_enable_ff && busy |=> write_collision_flag_ff && sr_ff == $past(rx_byte))
    else $error("collision not flagged or write not ignored");
  AST_IEN_ZERO: assert property (
    ar_hs && rd_idx == `IDX_INT_ENABLES && !buffered_operation_enable_ff
    |=> rdata[7:1] == 7'h00)
    else $error("buffer enables visible outside buffer mode");
  AST_SINGLE_IRQ: assert property (
    !buffered_operation_enable_ff && $stable(buffered_operation_enable_ff) && ien_ff[0] && if_ff |=> irq_req)
    else $error("normal request not raised");
  AST_DRE_DROP: assert property (
    wr_to_buf && !move_tx |=> !dre)
    else $error("empty flag not dropped on buffer write");
endmodule
`default_nettype wire

/* File: tb/spi_peer.sv */
// serial peer: slave model that shifts a loaded byte out and one in
`default_nettype none
module spi_peer (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [1:0] mode,
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  wire        samp = ~(mode[1] ^ mode[0]);
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    sh = 8'h00;
  end
  // phase 1 puts the first bit out on the leading edge
  always @(posedge load) begin
    sh = mode[0] ? tx : {tx[6:0], 1'b0};
    miso = mode[0] ? ~miso : tx[7];
  end
  // released line shows no stale value
  always @(posedge sel_n) miso = ~miso;
  always @(sck) begin
    if (!sel_n && sck == samp) begin
      rx = {rx[6:0], mosi};
    end else if (!sel_n) begin
      miso = sh[7];
      sh = {sh[6:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

/* File: tb/spi_control_and_flags_tb_top.sv */
// bench for the serial controller in master role
`default_nettype none
module spi_control_and_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        ss_dir_input, vector_ack, ss_n_in, load, sel_n, sck_q;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, mode, rs;
  logic        awready, wready, bvalid, arready, rvalid, irq_req;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        pmiso;
  logic [7:0]  tx, prx, rd, ca, d, p, d2;
  int          n_errors, cmp_count, cnt, hp;
  spi_ctrl spi_ctrl_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ss_dir_input(ss_dir_input),
    .vector_ack(vector_ack), .sck_in(sck_out), .mosi_in(mosi_out),
    .miso_in(miso_oe ? miso_out : pmiso), .ss_n_in(ss_n_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
    .irq_req(irq_req));
  spi_peer spi_peer_i (.sck(sck_out), .mosi(mosi_out), .sel_n(sel_n),
    .mode(mode), .load(load), .tx(tx), .miso(pmiso), .rx(prx));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // half period of the generated serial clock, in cycles
  always @(posedge aclk) begin
    cnt <= (sck_out != sck_q) ? 1 : cnt + 1;
    if (sck_out != sck_q) hp <= cnt;
    sck_q <= sck_out;
  end
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int i = 0; i < 99; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        return;
      end
    end
    n_errors++;
    wrap_up();
  endtask
  task automatic rdr(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    for (int i = 0; i < 99; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata[7:0];
        rs = rresp;
        return;
      end
    end
    n_errors++;
    wrap_up();
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    rdr(a);
    chk(rd, e);
  endtask
  task automatic waitf();
    for (int i = 0; i < 1000; i++) begin
      rdr(5'h0c);
      if (rd[7]) return;
    end
    n_errors++;
    wrap_up();
  endtask
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev[i] = b[7-i];
  endfunction
  function automatic logic [7:0] half(input logic [7:0] c);
    logic [2:0] s;
    s = {c[2:1], 1'b0} - {2'h0, &c[2:1]};
    half = (8'h02 << s) >> c[4];
  endfunction
  initial begin
    {aresetn, awvalid, wvalid, arvalid, vector_ack, load} = 6'h00;
    {ss_dir_input, sel_n, sck_q, cnt, hp} = '0;
    {bready, rready, ss_n_in} = 3'h7;
    {awaddr, araddr, wdata, tx, mode, n_errors, cmp_count} = '0;
    wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(98));
    for (int a = 0; a < 5; a++) rchk(5'(4 * a), 8'h00); // reset values
    rchk(5'h14, 8'h00);
    chk({6'h0, rs}, 8'h02); // unmapped place
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      wr(5'h00, d);
      rchk(5'h00, d & 8'h77);
      wr(5'h04, d);
      rchk(5'h04, d & 8'hc7);
      wr(5'h00, 8'h00);
      wr(5'h04, 8'h00);
    end
    wr(5'h08, 8'hf1);
    rchk(5'h08, 8'h01);
    for (int k = 0; k < 8; k++) begin
      ca = {1'b0, k[2], 1'b1, k[2], 1'b0, k[1], k[0] | ~k[1], 1'b1};
      d = 8'($urandom);
      p = 8'($urandom);
      mode <= k[1:0];
      wr(5'h04, {6'h0, k[1:0]});
      wr(5'h00, ca);
      tx <= p;
      load <= 1'b1;
      @(posedge aclk);
      load <= 1'b0;
      wr(5'h10, d);
      waitf();
      chk({7'h0, irq_req}, 8'h01);
      chk(8'(hp), half(ca));
      chk(prx, ca[6] ? rev(d) : d);
      chk({7'h0, sck_out}, {7'h0, k[1]});
      chk({7'h0, mosi_oe}, 8'h01);
      rdr(5'h10);
      chk(rd, ca[6] ? rev(p) : p);
      rchk(5'h0c, 8'h00);
      chk({7'h0, irq_req}, 8'h00);
    end
    // fastest divider: outgoing byte and half period, then write collision flag and disabled engine
    d = 8'($urandom);
    wr(5'h00, 8'h21);
    wr(5'h10, d);
    waitf();
    chk(8'(hp), 8'h02);
    chk(prx, d);
    rdr(5'h10);
    wr(5'h10, 8'($urandom));
    wr(5'h10, 8'($urandom));
    rchk(5'h0c, 8'h40);
    rdr(5'h10);
    rdr(5'h0c);
    chk({7'h0, rd[6]}, 8'h00);
    waitf();
    rdr(5'h10);
    wr(5'h00, 8'h20);
    wr(5'h10, 8'h5a);
    rchk(5'h0c, 8'h00);
    chk({7'h0, sck_oe}, 8'h00);
    // buffered, direct first load, second byte through the buffer
    mode <= 2'h0;
    wr(5'h04, 8'hc0);
    wr(5'h00, 8'h23);
    wr(5'h08, 8'h80);
    rchk(5'h08, 8'h80);
    p = 8'($urandom);
    d = 8'($urandom);
    d2 = 8'($urandom);
    tx <= p;
    load <= 1'b1;
    @(posedge aclk);
    load <= 1'b0;
    wr(5'h10, d);
    wr(5'h10, d2);
    rchk(5'h0c, 8'h00);
    waitf();
    chk(rd, 8'ha0);
    chk({7'h0, irq_req}, 8'h01);
    chk(prx, d);
    rdr(5'h10);
    chk(rd, p);
    waitf();
    chk(rd, 8'he0);
    chk(prx, d2);
    wr(5'h0c, 8'hc0);
    wr(5'h04, 8'h00);
    wr(5'h08, 8'h01);
    ss_dir_input <= 1'b1;
    wr(5'h04, 8'h04);
    wr(5'h00, 8'h21);
    ss_n_in <= 1'b0;
    rchk(5'h00, 8'h21);
    wr(5'h04, 8'h00);
    rchk(5'h00, 8'h01);
    rchk(5'h0c, 8'h80);
    chk({7'h0, irq_req}, 8'h01);
    vector_ack <= 1'b1;
    @(posedge aclk);
    vector_ack <= 1'b0;
    rchk(5'h0c, 8'h00);
    wrap_up();
  end
  initial begin
    repeat (90000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
